// >>> design/sweep_gen.sv
`timescale 1ns/1ps
`include "sweep_gen_cfg.svh"
module swg_sweep_generator #(
    parameter int ACC_WIDTH = 32,
    parameter int TMR_WIDTH = 16
) (
    input  wire logic               core_clk,
    input  wire logic               resetn,
    input  wire swg_pkg::swg_ctrl_type   ctrl_shadow,
    input  wire swg_pkg::swg_params_type params,
    input  wire swg_pkg::swg_dds_type    profile_values,
    input  wire logic               io_update,
    input  wire logic               sweep_direction_pin,
    input  wire logic               sweep_hold_pin,
    output swg_pkg::swg_dds_type         dds_params,
    output logic                         sweep_limit_flag_pin,
    output logic [31:0]                  ramp_value
);
    // =====================================================================
    // Elaboration check
    if (ACC_WIDTH != 32 || TMR_WIDTH != 16) begin : g_bad_width
        $error("Ramp widths other than 32/16 are not supported");
    end

    // =====================================================================
    // State
    swg_pkg::swg_state_type st;
    swg_pkg::swg_state_type next_st;

    logic [31:0] lower;
    logic [31:0] upper;
    logic [31:0] step_up;
    logic [31:0] step_down;
    logic [15:0] rate_up;
    logic [15:0] rate_down;
    logic        dds_tick;
    logic        upd_now;
    logic        enable_rise;
    logic        dir_change;
    logic        reload;
    logic        expire;
    logic [32:0] sum_up;
    logic [32:0] diff_down;

    assign lower     = params.bounds[31:0];
    assign upper     = params.bounds[63:32];
    assign step_up   = params.step_sizes[31:0];
    assign step_down = params.step_sizes[63:32];
    assign rate_up   = params.interval[`SWG_RATE_POS_LSB +: 16];  // [R8]
    assign rate_down = params.interval[`SWG_RATE_NEG_LSB +: 16];  // [R8]

    // =====================================================================
    // DDS clock enable, a quarter of the system clock
    assign dds_tick = (st.div_cnt == 2'(`SWG_DDS_DIV - 1));  // [R7]
    // Update strobe is caught and applied on the next DDS tick
    assign upd_now     = dds_tick && (st.update_seen || io_update);  // [R22]
    assign enable_rise = upd_now && ctrl_shadow.enable && !st.active.enable;
    assign dir_change  = sweep_direction_pin != st.dir_last;
    assign reload      = enable_rise || dir_change
                         || (upd_now && ctrl_shadow.reload_on_update);  // [R11]
    assign expire      = (st.timer <= 16'h0001);

    // Saturating arithmetic; 33 bits catch the carry or borrow
    assign sum_up    = {1'b0, st.accum} + {1'b0, step_up};
    assign diff_down = {1'b0, st.accum} - {1'b0, step_down};

    function automatic logic [31:0] clamp_up(input logic [32:0] s, input logic [31:0] hi);
        clamp_up = (s[32] || s[31:0] > hi) ? hi : s[31:0];  // [R23]
    endfunction : clamp_up

    function automatic logic [31:0] clamp_dn(input logic [32:0] d, input logic [31:0] lo);
        clamp_dn = (d[32] || d[31:0] < lo) ? lo : d[31:0];  // [R23]
    endfunction : clamp_dn

    always_comb begin
        next_st = st;
        next_st.div_cnt = st.div_cnt + 2'h1;
        if (io_update && !dds_tick) begin
            next_st.update_seen = 1'b1;
        end
        if (upd_now) begin
            next_st.update_seen = 1'b0;
            next_st.active      = ctrl_shadow;  // [R22] [R15] [R18]
            next_st.autoclear_pend = ctrl_shadow.autoclear;  // [R19]
        end
        // Disabled: the ramp logic sits still, pins ignored  [R1]
        if (dds_tick && st.active.enable) begin
            next_st.dir_last = sweep_direction_pin;
            if (st.active.clear || st.autoclear_pend) begin
                next_st.accum = lower;  // [R14] [R18] [R19]
                next_st.autoclear_pend = upd_now && ctrl_shadow.autoclear;
                next_st.timer = sweep_direction_pin ? rate_up : rate_down;
            end else if (!sweep_hold_pin
                         && !st.active.no_dwell_high && !st.active.no_dwell_low) begin  // [R5] [R20]
                if (reload) begin
                    next_st.timer = sweep_direction_pin ? rate_up : rate_down;  // [R11]
                end else if (expire) begin
                    next_st.timer = sweep_direction_pin ? rate_up : rate_down;
                    // Stepping from a held limit resumes once limit moves [R16] [R17]
                    if (sweep_direction_pin) begin
                        next_st.accum = clamp_up(sum_up, upper);  // [R4] [R9] [R12] [R16]
                    end else begin
                        next_st.accum = clamp_dn(diff_down, lower);  // [R4] [R9] [R12] [R17]
                    end
                end else begin
                    next_st.timer = st.timer - 16'h0001;  // [R7]
                end
            end
        end
        // First update with enable: direction picks the start  [R15]
        if (enable_rise) begin
            next_st.accum    = lower;
            next_st.dir_last = sweep_direction_pin;
            next_st.timer    = sweep_direction_pin ? 16'h0001 : rate_down;
        end
        // Destination routing, MSB aligned; others from profile  [R2] [R3] [R6] [R10]
        next_st.dds_out = profile_values;
        if (st.active.enable) begin
            if (st.active.destination == `SWG_DEST_FREQ) begin
                next_st.dds_out.frequency = st.accum;
            end else if (st.active.destination == `SWG_DEST_PHASE) begin
                next_st.dds_out.phase = st.accum[`SWG_PHASE_MSB:`SWG_PHASE_LSB];
            end else begin
                next_st.dds_out.amplitude = st.accum[31:`SWG_AMPL_LSB];
            end
        end
        next_st.limit_flag = st.active.enable && st.active.limit_flag_active
                             && (st.accum == lower || st.accum == upper);  // [R21]
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dds_params           = st.dds_out;
    assign sweep_limit_flag_pin = st.limit_flag;
    assign ramp_value           = st.accum;
endmodule : swg_sweep_generator

// >>> design/sweep_gen_cfg.svh
// Contract
// [R1] Enable cleared: ignore inputs, stop ramp clocks
// [R2] Destination field routes ramp: frequency, phase, amplitude
// [R3] Ramp output MSB-aligned to chosen destination
// [R4] Direction pin low falls, high rises
// [R5] Hold pin high freezes accumulator and output
// [R6] Unselected parameters come from active profile
// [R7] 32-bit accumulator stepped by timer on DDS clock
// [R8] Two 16-bit intervals, rising and falling
// [R9] Add rising step, subtract falling step
// [R10] Full precision; phase/amplitude truncated to MSBs
// [R11] Timer reload: enable rise, direction change, reload bit
// [R12] Output kept within lower and upper limits
// [R13] Software keeps upper limit above lower limit
// [R14] Clear presets accumulator to lower limit
// [R15] Enable effective at update; direction decides start
// [R16] Stay at upper limit until released
// [R17] Stay at lower limit until released
// [R18] Clear bit at update holds lower limit
// [R19] Autoclear holds accumulator reset one DDS cycle
// [R20] Normal ramping only with no-dwell bits clear
// [R21] Limit flag high at either limit when active
// [R22] Control bits shadowed, copied on update
// [R23] Accumulator clamps at limits, never wraps
`ifndef SWEEP_GEN_CFG_SVH
`define SWEEP_GEN_CFG_SVH
`define SWG_DDS_DIV        4
`define SWG_DEST_FREQ      2'b00
`define SWG_DEST_PHASE     2'b01
`define SWG_PHASE_MSB      31
`define SWG_PHASE_LSB      16
`define SWG_AMPL_LSB       18
`define SWG_RATE_POS_LSB   0
`define SWG_RATE_NEG_LSB   16
`define SWG_RESET_WORD     32'h0000_0000
`endif

// >>> design/sweep_gen_pkg.sv
package swg_pkg;
    typedef struct packed {
        logic        enable;
        logic        clear;
        logic        autoclear;
        logic        reload_on_update;
        logic [1:0]  destination;
        logic        no_dwell_high;
        logic        no_dwell_low;
        logic        limit_flag_active;
    } swg_ctrl_type;

    typedef struct packed {
        logic [31:0] interval;
        logic [63:0] step_sizes;
        logic [63:0] bounds;
    } swg_params_type;

    typedef struct packed {
        logic [31:0] frequency;
        logic [15:0] phase;
        logic [13:0] amplitude;
    } swg_dds_type;

    typedef struct packed {
        logic [1:0]   div_cnt;
        swg_ctrl_type active;
        logic         update_seen;
        logic         dir_last;
        logic [15:0]  timer;
        logic [31:0]  accum;
        logic         autoclear_pend;
        swg_dds_type  dds_out;
        logic         limit_flag;
    } swg_state_type;
endpackage : swg_pkg

// >>> tb/swg_sweep_generator_monitor.sv
`timescale 1ns/1ps
// ====
// Port checks
module swg_sweep_generator_monitor (
    input wire logic                    core_clk,
    input wire logic                    resetn,
    input wire swg_pkg::swg_ctrl_type   ctrl_shadow,
    input wire swg_pkg::swg_params_type params,
    input wire swg_pkg::swg_dds_type    profile_values,
    input wire logic                    io_update,
    input wire logic                    sweep_direction_pin,
    input wire logic                    sweep_hold_pin,
    input wire swg_pkg::swg_dds_type    dds_params,
    input wire logic                    sweep_limit_flag_pin,
    input wire logic [31:0]             ramp_value
);
    // Eight cycles after an update the tick copy has surely landed
    logic       en;
    logic [1:0] dst;
    logic       lfa;
    logic [3:0] cnt;
    logic       ok;
    logic       lim;
    assign ok  = en && cnt >= 4'h8;
    assign lim = ramp_value == params.bounds[31:0] || ramp_value == params.bounds[63:32];
    always_ff @(posedge core_clk) begin
        if (!resetn || io_update) cnt <= 4'h0;
        else if (cnt != 4'hf) cnt <= cnt + 4'h1;
        // Shadow bits may change before the strobe, so track the copy taken at it
        if (!resetn) begin
            en  <= 1'b0;
            dst <= 2'h0;
            lfa <= 1'b0;
        end else if (io_update) begin
            en  <= ctrl_shadow.enable;
            dst <= ctrl_shadow.destination;
            lfa <= ctrl_shadow.limit_flag_active;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_off; !en && cnt >= 4'h8 |-> $stable(ramp_value); endproperty
    a_off: assert property (p_off) else $error("idle ramp moved");
    property p_frq; ok && dst == 2'h0 |-> dds_params ==
        {$past(ramp_value), $past(profile_values.phase), $past(profile_values.amplitude)};
    endproperty
    a_frq: assert property (p_frq) else $error("frequency route");
    property p_phs; ok && dst == 2'h1 |->
        dds_params.phase == ($past(ramp_value) >> 16); endproperty
    a_phs: assert property (p_phs) else $error("phase route");
    property p_amp; ok && dst[1] |->
        dds_params.amplitude == ($past(ramp_value) >> 18); endproperty
    a_amp: assert property (p_amp) else $error("amplitude route");
    property p_bnd; ok |-> ramp_value >= params.bounds[31:0] &&
        ramp_value <= params.bounds[63:32]; endproperty
    a_bnd: assert property (p_bnd) else $error("out of bounds");
    property p_flg; ok && lfa |-> sweep_limit_flag_pin == $past(lim);
    endproperty
    a_flg: assert property (p_flg) else $error("limit flag");
    // Pin must match the one sampled at the tick, hence the stable term
    property p_dir; ok && $changed(ramp_value) && $stable(sweep_direction_pin) |->
        (ramp_value > $past(ramp_value)) == sweep_direction_pin; endproperty
    a_dir: assert property (p_dir) else $error("slope sign");
    property p_hld; sweep_hold_pin && cnt >= 4'h8 |=> $stable(ramp_value); endproperty
    a_hld: assert property (p_hld) else $error("hold moved");
    c_top: cover property (ok && ramp_value == params.bounds[63:32]);
    c_hld: cover property (ok && sweep_hold_pin);
    c_amp: cover property (ok && dst[1]);
endmodule : swg_sweep_generator_monitor
bind swg_sweep_generator swg_sweep_generator_monitor u_swg_sweep_generator_monitor (.*);

// >>> tb/swg_ctrl_model.sv
`timescale 1ns/1ps
// ====
// Pin controller, changes pins only on the clock
module swg_ctrl_model (
    input  wire logic core_clk,
    input  wire logic dir_req,
    input  wire logic hold_req,
    input  wire logic upd_req,
    output logic      io_update,
    output logic      sweep_direction_pin,
    output logic      sweep_hold_pin
);
    initial {io_update, sweep_direction_pin, sweep_hold_pin} = 3'h0;
    always @(posedge core_clk) begin
        sweep_direction_pin <= dir_req;
        sweep_hold_pin      <= hold_req;
        io_update           <= upd_req;
    end
endmodule : swg_ctrl_model

// >>> tb/swg_sweep_generator_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
// ====
// Bench
module swg_sweep_generator_tb_top;
    logic core_clk = 1'b0, resetn = 1'b0, dir_req = 1'b0, hold_req = 1'b0, upd_req = 1'b0, s;
    logic io_update, sweep_direction_pin, sweep_hold_pin, sweep_limit_flag_pin;
    logic [31:0] v, ramp_value;
    int bad_count = 0, n_compared = 0;
    swg_pkg::swg_ctrl_type ctrl_shadow = '0;
    // Upper stays above lower in every scenario
    swg_pkg::swg_params_type params = {32'h0001_0002, 64'h80_0000_0040, 64'h400_0000_0100};
    swg_pkg::swg_dds_type profile_values = {32'h1234_5678, 16'habcd, 14'h1555}, dds_params;
    swg_ctrl_model u_swg_ctrl_model (.*);
    swg_sweep_generator u_swg_sweep_generator (.*);
    always #20 core_clk = ~core_clk;
    task automatic wt(input int n); repeat (n) @(posedge core_clk); endtask : wt
    task automatic pulse; @(posedge core_clk) upd_req <= 1'b1;
        @(posedge core_clk) upd_req <= 1'b0; endtask : pulse
    task automatic upd; pulse(); wt(12); endtask : upd
    task automatic t_rise; ctrl_shadow.enable <= 1'b1; ctrl_shadow.limit_flag_active <= 1'b1;
        dir_req <= 1'b1; upd(); wt(200);
        `CHK("top", 32'h0000_0400, ramp_value)
        `CHK("flag", 1'b1, sweep_limit_flag_pin)
        params.bounds[63:32] <= 32'h0000_0500; wt(60);
        `CHK("raised", 32'h0000_0500, ramp_value)
    endtask : t_rise
    task automatic t_fall; dir_req <= 1'b0; wt(200);
        `CHK("bottom", 32'h0000_0100, ramp_value)
        params.bounds[31:0] <= 32'h0000_0080; wt(40);
        `CHK("lowered", 32'h0000_0080, ramp_value)
    endtask : t_fall
    task automatic t_hold; dir_req <= 1'b1; wt(20); hold_req <= 1'b1; wt(8); v = ramp_value;
        wt(40);
        `CHK("held", v, ramp_value)
        hold_req <= 1'b0; wt(20);
        `CHK("resumed", 1'b1, ramp_value > v)
    endtask : t_hold
    task automatic t_clear; ctrl_shadow.clear <= 1'b1; upd(); wt(20);
        `CHK("cleared", 32'h0000_0080, ramp_value)
        ctrl_shadow.clear <= 1'b0; upd(); wt(20);
        `CHK("restart", 1'b1, ramp_value > 32'h0000_0080)
        ctrl_shadow.autoclear <= 1'b1; s = 1'b0; pulse();
        repeat (12) @(posedge core_clk) if (ramp_value === 32'h0000_0080) s = 1'b1;
        `CHK("autoclr", 1'b1, s)
        wt(20);
        `CHK("autorun", 1'b1, ramp_value > 32'h0000_0080)
    endtask : t_clear
    task automatic t_dest; ctrl_shadow.autoclear <= 1'b0;
        for (int d = 0; d < 4; d++) begin
            ctrl_shadow.destination <= d[1:0]; ctrl_shadow.reload_on_update <= d[0]; upd(); wt(30);
        end
        ctrl_shadow.enable <= 1'b0; upd(); v = ramp_value; dir_req <= 1'b0; wt(40);
        `CHK("off", v, ramp_value)
        `CHK("profile", profile_values, dds_params)
    endtask : t_dest
    task automatic finish_test; if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish; endtask : finish_test
    initial begin
        wt(4); resetn <= 1'b1;
        t_rise(); t_fall(); t_hold(); t_clear(); t_dest(); finish_test();
    end
    // Runs take about 940 cycles; this allows over five times that
    initial begin #200000; bad_count++; finish_test(); end
endmodule : swg_sweep_generator_tb_top
